/* File: usf_flags.sv */
`timescale 1ns/10ps
// Function
// - Ten sources in three request groups: transmit, receive, error; each locally enabled.
// - Flags keep updating and stay readable while their enables are clear.
// - Transmit-empty flag tracks free buffer; request while flag and enable set.
// - Transmit-done only when everything sent and line idle; requests when enabled.
// - Receive-full clears after status read with flag set, then data read.
// - Idle flag clears after status read with flag set, then data read.
// - Cleared idle stays clear until a new character sets receive-full.
// - Noise, framing, parity flags set together with receive-full, never on overrun.
// - Character arriving while receive-full set raises overrun and is discarded.
// - With receiver on, falling input edge sets edge flag; write one clears.
// - Nine-bit mode carries a ninth bit both directions.
// - Ninth transmit bit copied with the byte load and retained.
// - Stop halts the block; light keeps registers, deep loses them.
// - Edge detection runs in light stop; enabled edge requests wake.
// - Loop mode feeds transmitter output to receiver and releases the input pin.
// - Single-wire mode: receiver hears transmitter and output pin; input pin released.
// - Single-wire direction bit: zero makes output pin an input, one drives it.
// - In single-wire mode with direction bit one the receiver hears its own transmitted characters.
// - With idle wake flag enabled, idle sets even while receiver sleeps.
module usf_flags (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic [2:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [7:0] rdata,
	input wire usf_pkg::usf_rx_char_type rx_char,
	input wire logic rx_idle_det,
	input wire logic rx_asleep,
	input wire logic lin_break_det,
	input wire logic tx_load_req,
	input wire logic tx_line,
	input wire logic tx_idle,
	output usf_pkg::usf_tx_load_type tx_out,
	output logic rx_line,
	output logic rx_enable,
	output logic nine_bit_mode,
	input wire logic serial_in_pin,
	input wire logic serial_out_i,
	output logic serial_out_o,
	output logic serial_out_oe,
	output logic serial_in_released,
	input wire logic stop_light,
	input wire logic stop_deep,
	output logic irq_tx,
	output logic irq_rx,
	output logic irq_err,
	output logic wake_req
);
	usf_pkg::usf_state_type s_q;
	usf_pkg::usf_state_type s_d;

	always_comb begin
		logic loop;
		logic swire;
		logic rx_src;
		logic act;
		logic take;
		logic tx_empty_flag;
		logic tc;
		loop = 1'b0;
		swire = 1'b0;
		rx_src = 1'b1;
		act = 1'b0;
		take = 1'b0;
		tx_empty_flag = 1'b0;
		tc = 1'b0;
		s_d = s_q;
		s_d.txo.load = 1'b0;
		s_d.rdata = 8'h00;
		act = ~stop_light;
		// Pin synchronisers run even in light stop so edge wake still works
		s_d.in_sync = {s_q.in_sync[0], serial_in_pin};
		s_d.out_sync = {s_q.out_sync[0], serial_out_i};
		loop = s_q.ctrl1[usf_pkg::C1_LOOP];
		swire = loop & s_q.ctrl1[usf_pkg::C1_RX_SOURCE_SEL];
		// Receiver input routing
		if (loop && !swire) begin
			rx_src = tx_line;
		end else if (swire) begin
			if (s_q.ctrl3[usf_pkg::C3_DIR]) begin
				rx_src = tx_line;
			end else begin
				rx_src = s_q.out_sync[1];
			end
		end else begin
			rx_src = s_q.in_sync[1];
		end
		s_d.rx_line = rx_src;
		s_d.rx_prev = s_q.rx_line;
		s_d.pin_release = loop;
		s_d.pin_o = tx_line;
		s_d.pin_oe = ~swire | s_q.ctrl3[usf_pkg::C3_DIR];
		// Edge flag: idle-high line, so the active edge is falling
		if (s_q.ctrl2[usf_pkg::C2_RXON] && s_q.rx_prev && !s_q.rx_line) begin
			s_d.rx_edge = 1'b1;
		end else if (act && wr && addr == usf_pkg::ADDR_STAT2 && wdata[usf_pkg::S2_EDGE]) begin
			s_d.rx_edge = 1'b0;
		end
		s_d.wake = s_q.rx_edge & s_q.stat2_en[usf_pkg::S2_EDGEIE];
		if (act) begin
			// Register writes
			if (wr) begin
				unique case (addr)
					usf_pkg::ADDR_CTRL1: s_d.ctrl1 = wdata & usf_pkg::C1_MASK;
					usf_pkg::ADDR_CTRL2: s_d.ctrl2 = wdata & usf_pkg::C2_MASK;
					usf_pkg::ADDR_STAT2: begin
						s_d.stat2_en = wdata & usf_pkg::S2_EN_MASK;
						if (wdata[usf_pkg::S2_LBK]) begin
							s_d.lbk = 1'b0;
						end
					end
					usf_pkg::ADDR_CTRL3: s_d.ctrl3 = wdata & usf_pkg::C3_MASK;
					usf_pkg::ADDR_DATA: begin
						s_d.tx_data = wdata;
						s_d.tx_buf_full = 1'b1;
					end
					default: ;
				endcase
			end
			// Transmit buffer to shifter; ninth bit copied with the byte
			if (tx_load_req && s_q.tx_buf_full) begin
				s_d.txo.load = 1'b1;
				s_d.txo.data = {s_q.ctrl3[usf_pkg::C3_T9] & s_q.ctrl1[usf_pkg::C1_NINE], s_q.tx_data};
				if (!(wr && addr == usf_pkg::ADDR_DATA)) begin
					s_d.tx_buf_full = 1'b0;
				end
			end
			s_d.tx_not_done = s_d.tx_buf_full | ~tx_idle;
			// Clear sequence step one: arm on status read
			if (rd && addr == usf_pkg::ADDR_STAT1) begin
				s_d.rx_full_flag_arm = s_q.rx_full_flag;
				s_d.idle_arm = s_q.idle;
				s_d.err_arm = s_q.ovr | s_q.nf | s_q.fe | s_q.pf;
			end
			// Step two: data read clears what was armed
			if (rd && addr == usf_pkg::ADDR_DATA) begin
				s_d.rx_full_flag_arm = 1'b0;
				s_d.idle_arm = 1'b0;
				s_d.err_arm = 1'b0;
				if (s_q.rx_full_flag_arm) begin
					s_d.rx_full_flag = 1'b0;
				end
				if (s_q.idle_arm) begin
					s_d.idle = 1'b0;
					s_d.idle_lock = 1'b1;
				end
				if (s_q.err_arm) begin
					s_d.ovr = 1'b0;
					s_d.nf = 1'b0;
					s_d.fe = 1'b0;
					s_d.pf = 1'b0;
				end
			end
			// Hardware sets come last so they win over a same-cycle clear
			if (rx_char.valid && s_q.ctrl2[usf_pkg::C2_RXON]) begin
				if (s_q.rx_full_flag) begin
					s_d.ovr = 1'b1;
				end else begin
					s_d.rx_full_flag = 1'b1;
					s_d.idle_lock = 1'b0;
					s_d.rx_data[7:0] = rx_char.data[7:0];
					s_d.rx_data[8] = rx_char.data[8] & s_q.ctrl1[usf_pkg::C1_NINE];
					s_d.nf = s_d.nf | rx_char.noise;
					s_d.fe = s_d.fe | rx_char.frame;
					s_d.pf = s_d.pf | rx_char.parity;
				end
			end
			if (rx_idle_det && !s_q.idle_lock && (!rx_asleep || s_q.ctrl2[usf_pkg::C2_IDWF])) begin
				s_d.idle = 1'b1;
			end
			if (lin_break_det) begin
				s_d.lbk = 1'b1;
			end
			// Register reads, data one cycle later
			if (rd) begin
				unique case (addr)
					usf_pkg::ADDR_CTRL1: s_d.rdata = s_q.ctrl1;
					usf_pkg::ADDR_CTRL2: s_d.rdata = s_q.ctrl2;
					usf_pkg::ADDR_STAT1: s_d.rdata = {~s_q.tx_buf_full, ~s_q.tx_not_done, s_q.rx_full_flag, s_q.idle,
						s_q.ovr, s_q.nf, s_q.fe, s_q.pf};
					usf_pkg::ADDR_STAT2: s_d.rdata = {s_q.lbk, s_q.rx_edge, 4'h0, s_q.stat2_en[1:0]};
					usf_pkg::ADDR_CTRL3: s_d.rdata = {s_q.rx_data[8], s_q.ctrl3[6:0]};
					usf_pkg::ADDR_DATA: s_d.rdata = s_q.rx_data[7:0];
					default: s_d.rdata = 8'h00;
				endcase
			end
		end
		// Requests follow the next flag values so they line up with the flags
		tx_empty_flag = ~s_d.tx_buf_full;
		tc = ~s_d.tx_not_done;
		s_d.irq_tx = (tx_empty_flag & s_d.ctrl2[usf_pkg::C2_TIE]) | (tc & s_d.ctrl2[usf_pkg::C2_TX_DONE_IRQ_EN]);
		s_d.irq_rx = (s_d.rx_full_flag & s_d.ctrl2[usf_pkg::C2_RIE]) | (s_d.idle & s_d.ctrl2[usf_pkg::C2_ILIE])
			| (s_d.rx_edge & s_d.stat2_en[usf_pkg::S2_EDGEIE])
			| (s_d.lbk & s_d.stat2_en[usf_pkg::S2_LBKIE]);
		s_d.irq_err = (s_d.ovr & s_d.ctrl3[usf_pkg::C3_ORIE]) | (s_d.nf & s_d.ctrl3[usf_pkg::C3_NFIE])
			| (s_d.fe & s_d.ctrl3[usf_pkg::C3_FEIE]) | (s_d.pf & s_d.ctrl3[usf_pkg::C3_PFIE]);
		// Deep stop powers the block down; contents come back as after reset
		if (stop_deep) begin
			s_d = '0;
		end else if (stop_light) begin
			s_d.irq_tx = s_q.irq_tx;
			s_d.irq_rx = s_q.irq_rx | s_d.wake;
			s_d.irq_err = s_q.irq_err;
			s_d.pin_o = s_q.pin_o;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign rdata = s_q.rdata;
	assign tx_out = s_q.txo;
	assign rx_line = s_q.rx_line;
	assign rx_enable = s_q.ctrl2[usf_pkg::C2_RXON];
	assign nine_bit_mode = s_q.ctrl1[usf_pkg::C1_NINE];
	assign serial_out_o = s_q.pin_o;
	assign serial_out_oe = s_q.pin_oe;
	assign serial_in_released = s_q.pin_release;
	assign irq_tx = s_q.irq_tx;
	assign irq_rx = s_q.irq_rx;
	assign irq_err = s_q.irq_err;
	assign wake_req = s_q.wake;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!reset_n);

	logic run;
	assign run = ~stop_light & ~stop_deep;

	sequence seq_stat_read_full;
		run && rd && addr == usf_pkg::ADDR_STAT1 && s_q.rx_full_flag;
	endsequence
	sequence seq_data_read;
		run && rd && addr == usf_pkg::ADDR_DATA && !rx_char.valid;
	endsequence

	a_rx_full_flag_clear_seq: assert property (seq_stat_read_full ##1 (run && !rd && !wr) ##1 seq_data_read
		|=> !s_q.rx_full_flag)
		else $error("receive-full not cleared by status then data read");
	a_rx_full_flag_needs_status: assert property (run && !s_q.rx_full_flag_arm && rd && addr == usf_pkg::ADDR_DATA && s_q.rx_full_flag
		|=> s_q.rx_full_flag)
		else $error("receive-full cleared without status read");
	a_overrun_drop: assert property (run && rx_char.valid && s_q.rx_full_flag && rx_enable
		|=> s_q.ovr && $stable(s_q.rx_data))
		else $error("overrun not flagged or data overwritten");
	a_error_with_full: assert property (run && rx_char.valid && !s_q.rx_full_flag && rx_enable && rx_char.noise
		|=> s_q.nf && s_q.rx_full_flag)
		else $error("noise flag not set with receive-full");
	a_idle_locked: assert property (run && s_q.idle_lock && !rx_char.valid |=> !s_q.idle)
		else $error("idle set again without a new character");
	a_edge_sets: assert property (rx_enable && s_q.rx_prev && !rx_line && !stop_deep |=> s_q.rx_edge)
		else $error("edge flag missed an active edge");
	a_tx_request: assert property (run && !s_q.tx_buf_full && !(wr && addr == usf_pkg::ADDR_DATA)
		&& s_d.ctrl2[usf_pkg::C2_TIE] |=> irq_tx)
		else $error("transmit request missing while buffer empty");
	a_ninth_copy: assert property (run && tx_load_req && s_q.tx_buf_full
		|=> tx_out.load && tx_out.data[8] == $past(s_q.ctrl3[usf_pkg::C3_T9] & nine_bit_mode))
		else $error("ninth bit not copied with byte load");
	a_loop_route: assert property (run && s_q.ctrl1[usf_pkg::C1_LOOP] && !s_q.ctrl1[usf_pkg::C1_RX_SOURCE_SEL]
		|=> rx_line == $past(tx_line))
		else $error("loop mode does not feed receiver from transmitter");
	a_wire_dir: assert property (run && s_q.ctrl1[usf_pkg::C1_LOOP] && s_q.ctrl1[usf_pkg::C1_RX_SOURCE_SEL]
		|=> serial_out_oe == $past(s_q.ctrl3[usf_pkg::C3_DIR]))
		else $error("single-wire pin direction wrong");
	a_deep_loss: assert property (stop_deep |=> !irq_tx && !s_q.rx_full_flag && s_q.ctrl2 == 8'h00)
		else $error("deep stop kept register contents");
endmodule

/* File: usf_pkg.sv */
package usf_pkg;
	// Register addresses on the plain register port
	localparam logic [2:0] ADDR_CTRL1 = 3'h0;
	localparam logic [2:0] ADDR_CTRL2 = 3'h1;
	localparam logic [2:0] ADDR_STAT1 = 3'h2;
	localparam logic [2:0] ADDR_STAT2 = 3'h3;
	localparam logic [2:0] ADDR_CTRL3 = 3'h4;
	localparam logic [2:0] ADDR_DATA = 3'h5;
	// control_reg_one fields
	localparam int C1_LOOP = 7;
	localparam int C1_RX_SOURCE_SEL = 5;
	localparam int C1_NINE = 4;
	// control_reg_two fields
	localparam int C2_TIE = 7;
	localparam int C2_TX_DONE_IRQ_EN = 6;
	localparam int C2_RIE = 5;
	localparam int C2_ILIE = 4;
	localparam int C2_RXON = 2;
	localparam int C2_IDWF = 1;
	// status_reg_one fields
	localparam int S1_TX_EMPTY_FLAG = 7;
	localparam int S1_TC = 6;
	localparam int S1_RX_FULL_FLAG = 5;
	localparam int S1_IDLE = 4;
	localparam int S1_OVR = 3;
	localparam int S1_NF = 2;
	localparam int S1_FE = 1;
	localparam int S1_PF = 0;
	// status_reg_two fields: flags high, their enables low
	localparam int S2_LBK = 7;
	localparam int S2_EDGE = 6;
	localparam int S2_LBKIE = 1;
	localparam int S2_EDGEIE = 0;
	// control_reg_three fields
	localparam int C3_R9 = 7;
	localparam int C3_T9 = 6;
	localparam int C3_DIR = 5;
	localparam int C3_ORIE = 3;
	localparam int C3_NFIE = 2;
	localparam int C3_FEIE = 1;
	localparam int C3_PFIE = 0;
	// Writable bits per register; the rest read as zero, except R9 in control_reg_three and the status_reg_two flags
	localparam logic [7:0] C1_MASK = 8'hB0;
	localparam logic [7:0] C2_MASK = 8'hF6;
	localparam logic [7:0] S2_EN_MASK = 8'h03;
	localparam logic [7:0] C3_MASK = 8'h6F;

	typedef struct packed {
		logic valid;
		logic [8:0] data;
		logic noise;
		logic frame;
		logic parity;
	} usf_rx_char_type;

	typedef struct packed {
		logic load;
		logic [8:0] data;
	} usf_tx_load_type;

	typedef struct packed {
		logic [7:0] ctrl1;
		logic [7:0] ctrl2;
		logic [7:0] ctrl3;
		logic [7:0] stat2_en;
		logic tx_buf_full;
		logic tx_not_done;
		logic [7:0] tx_data;
		logic rx_full_flag;
		logic idle;
		logic ovr;
		logic nf;
		logic fe;
		logic pf;
		logic rx_edge;
		logic lbk;
		logic [8:0] rx_data;
		logic rx_full_flag_arm;
		logic idle_arm;
		logic err_arm;
		logic idle_lock;
		logic [1:0] in_sync;
		logic [1:0] out_sync;
		logic rx_prev;
		logic rx_line;
		logic [7:0] rdata;
		logic irq_tx;
		logic irq_rx;
		logic irq_err;
		logic wake;
		usf_tx_load_type txo;
		logic pin_o;
		logic pin_oe;
		logic pin_release;
	} usf_state_type;
endpackage

/* File: usf_shift_model.sv */
`timescale 1ns/10ps
// Stand-in for the transmit shifter; one bit per clock keeps frames short
module usf_shift_model (
	input wire logic clk,
	input wire logic reset_n,
	input wire usf_pkg::usf_tx_load_type tx_out,
	output logic tx_load_req,
	output logic tx_line,
	output logic tx_idle
);
	logic [10:0] sh_q;
	logic [3:0] cnt_q;
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			sh_q <= 11'h7FF;
			cnt_q <= 4'h0;
		end else if (tx_out.load) begin
			sh_q <= {1'b1, tx_out.data, 1'b0};
			cnt_q <= 4'hB;
		end else if (cnt_q != 4'h0) begin
			sh_q <= {1'b1, sh_q[10:1]};
			cnt_q <= cnt_q - 4'h1;
		end
	end
	// Line rests high between frames
	assign tx_line = sh_q[0];
	assign tx_load_req = (cnt_q == 4'h0);
	assign tx_idle = (cnt_q == 4'h0);
endmodule

/* File: usf_flags_tb.sv */
`timescale 1ns/10ps
module usf_flags_tb;
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	logic [2:0] addr = 3'h0;
	logic [7:0] wdata = 8'h00;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [7:0] rdata;
	usf_pkg::usf_rx_char_type rx_char = '0;
	logic rx_idle_det = 1'b0;
	logic serial_in_pin = 1'b1;
	logic tx_load_req, tx_line, tx_idle, rx_line, rx_enable, nine_bit_mode;
	logic serial_out_i, serial_out_o, serial_out_oe, serial_in_released;
	logic irq_tx, irq_rx, irq_err, wake_req;
	usf_pkg::usf_tx_load_type tx_out;
	logic [8:0] tx_seen = 9'h000;
	logic tx_prev = 1'b1;
	int loads = 0;
	int mismatches = 0;
	int samples_checked = 0;
	logic [7:0] v, b0, b1;
	logic [2:0] e;

	always #25 clk = ~clk;
	// Released output pin floats to the pull-up level
	assign serial_out_i = serial_out_oe ? serial_out_o : 1'b1;

	usf_flags u_usf_flags (.clk(clk), .reset_n(reset_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata), .rx_char(rx_char), .rx_idle_det(rx_idle_det), .rx_asleep(1'b0), .lin_break_det(1'b0),
		.tx_load_req(tx_load_req), .tx_line(tx_line), .tx_idle(tx_idle), .tx_out(tx_out), .rx_line(rx_line),
		.rx_enable(rx_enable), .nine_bit_mode(nine_bit_mode), .serial_in_pin(serial_in_pin),
		.serial_out_i(serial_out_i), .serial_out_o(serial_out_o), .serial_out_oe(serial_out_oe),
		.serial_in_released(serial_in_released), .stop_light(1'b0), .stop_deep(1'b0), .irq_tx(irq_tx),
		.irq_rx(irq_rx), .irq_err(irq_err), .wake_req(wake_req));
	usf_shift_model u_usf_shift_model (.clk(clk), .reset_n(reset_n), .tx_out(tx_out),
		.tx_load_req(tx_load_req), .tx_line(tx_line), .tx_idle(tx_idle));

	always @(posedge clk) begin
		tx_prev <= tx_line;
		if (tx_out.load) begin
			tx_seen <= tx_out.data;
			loads <= loads + 1;
		end
	end

	task automatic check(input logic [8:0] got, input logic [8:0] exp);
		samples_checked++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic test_done;
		$display("Checks %0d, mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rd_chk(input logic [2:0] a, input logic [7:0] exp);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		check(rdata, exp);
	endtask
	task automatic send_char(input logic [8:0] d, input logic [2:0] err);
		@(posedge clk);
		rx_char <= {1'b1, d, err};
		@(posedge clk);
		rx_char.valid <= 1'b0;
	endtask
	task automatic pulse_idle;
		@(posedge clk);
		rx_idle_det <= 1'b1;
		@(posedge clk);
		rx_idle_det <= 1'b0;
		repeat (2) @(posedge clk);
	endtask
	task automatic wait_loads(input int n);
		for (int i = 0; i < 100 && loads < n; i++) @(posedge clk);
		if (loads < n) begin
			mismatches++;
			$display("[FAIL] %0t transmit load missing", $time);
			test_done();
		end
		@(posedge clk);
		#1;
	endtask
	// Receiver must track the transmitter one cycle late during a whole frame
	task automatic loop_chk;
		wr_reg(usf_pkg::ADDR_DATA, $urandom);
		repeat (14) begin
			@(posedge clk);
			#1;
			check(rx_line, tx_prev);
		end
	endtask

	initial begin
		v = $urandom(32'h8E06E35E);
		repeat (10) @(posedge clk);
		reset_n <= 1'b1;
		rd_chk(usf_pkg::ADDR_STAT1, 8'hC0);
		rd_chk(3'h6, 8'h00);
		$display("test reset done");
		wr_reg(usf_pkg::ADDR_CTRL2, 8'hC4);
		repeat (2) @(posedge clk);
		check(irq_tx, 1'b1);
		wr_reg(usf_pkg::ADDR_CTRL1, 8'h10);
		wr_reg(usf_pkg::ADDR_CTRL3, 8'h40);
		for (int k = 0; k < 3; k++) begin
			b0 = $urandom;
			if (k == 2)
				wr_reg(usf_pkg::ADDR_CTRL1, 8'h00);
			wr_reg(usf_pkg::ADDR_DATA, b0);
			wait_loads(k + 1);
			check(tx_seen, {k != 2, b0});
		end
		repeat (15) @(posedge clk);
		rd_chk(usf_pkg::ADDR_STAT1, 8'hC0);
		wr_reg(usf_pkg::ADDR_CTRL2, 8'h24);
		repeat (2) @(posedge clk);
		check(irq_tx, 1'b0);
		$display("test transmit done");
		wr_reg(usf_pkg::ADDR_CTRL3, 8'h08);
		b0 = $urandom;
		b1 = $urandom;
		e = $urandom;
		send_char({1'b0, b0}, e);
		repeat (2) @(posedge clk);
		check(irq_rx, 1'b1);
		send_char({1'b0, b1}, 3'h7);
		repeat (2) @(posedge clk);
		check(irq_err, 1'b1);
		rd_chk(usf_pkg::ADDR_STAT1, 8'hE8 | {5'h00, e});
		rd_chk(usf_pkg::ADDR_DATA, b0);
		rd_chk(usf_pkg::ADDR_STAT1, 8'hC0);
		check(irq_rx, 1'b0);
		wr_reg(usf_pkg::ADDR_CTRL1, 8'h10);
		send_char({1'b1, b1}, 3'h0);
		rd_chk(usf_pkg::ADDR_CTRL3, 8'h88);
		rd_chk(usf_pkg::ADDR_STAT1, 8'hE0);
		rd_chk(usf_pkg::ADDR_DATA, b1);
		$display("test receive done");
		wr_reg(usf_pkg::ADDR_CTRL2, 8'h14);
		pulse_idle();
		check(irq_rx, 1'b1);
		rd_chk(usf_pkg::ADDR_STAT1, 8'hD0);
		rd_chk(usf_pkg::ADDR_DATA, b1);
		rd_chk(usf_pkg::ADDR_STAT1, 8'hC0);
		pulse_idle();
		rd_chk(usf_pkg::ADDR_STAT1, 8'hC0);
		send_char({1'b0, b0}, 3'h0);
		pulse_idle();
		rd_chk(usf_pkg::ADDR_STAT1, 8'hF0);
		rd_chk(usf_pkg::ADDR_DATA, b0);
		$display("test idle done");
		wr_reg(usf_pkg::ADDR_STAT2, 8'h01);
		serial_in_pin <= 1'b0;
		for (int i = 0; i < 20 && wake_req !== 1'b1; i++) @(posedge clk);
		rd_chk(usf_pkg::ADDR_STAT2, 8'h41);
		wr_reg(usf_pkg::ADDR_STAT2, 8'h41);
		rd_chk(usf_pkg::ADDR_STAT2, 8'h01);
		wr_reg(usf_pkg::ADDR_CTRL2, 8'h00);
		serial_in_pin <= 1'b1;
		repeat (4) @(posedge clk);
		serial_in_pin <= 1'b0;
		repeat (8) @(posedge clk);
		rd_chk(usf_pkg::ADDR_STAT2, 8'h01);
		$display("test edge done");
		wr_reg(usf_pkg::ADDR_CTRL1, 8'h80);
		repeat (3) @(posedge clk);
		check(serial_in_released, 1'b1);
		loop_chk();
		wr_reg(usf_pkg::ADDR_CTRL1, 8'hA0);
		wr_reg(usf_pkg::ADDR_CTRL3, 8'h20);
		repeat (3) @(posedge clk);
		check(serial_out_oe, 1'b1);
		loop_chk();
		wr_reg(usf_pkg::ADDR_CTRL3, 8'h00);
		repeat (5) @(posedge clk);
		check(serial_out_oe, 1'b0);
		check(rx_line, 1'b1);
		wr_reg(usf_pkg::ADDR_CTRL1, 8'h00);
		repeat (3) @(posedge clk);
		check(serial_in_released, 1'b0);
		check(serial_out_oe, 1'b1);
		$display("test loop done");
		test_done();
	end
endmodule
